//--- core/irq_flag_defines.vh
// Register offsets, field positions and reset values of the request flag block.
// Assumes inclusion by bare name from the design file.
`ifndef IRQ_FLAG_DEFINES_VH
`define IRQ_FLAG_DEFINES_VH
`define ADDR_PERIPH_FLAGS 4'h0
`define ADDR_WAKEUP_FLAGS 4'h1
`define ADDR_WAKEUP_EDGE 4'h2
`define ADDR_PERIPH_ENABLE 4'h3
`define ADDR_EXT_FLAGS 4'h4
`define ADDR_EXT_ENABLE 4'h5
`define BIT_DT 7
`define BIT_AD 6
`define BIT_TFH 3
`define BIT_TFL 2
`define BIT_EC 0
`define PERIPH_IMPL_MASK 8'hcd
`define EXT_IMPL_MASK 8'h07
`define RST_FLAGS 8'h00
`define RST_EDGE 8'h00
`define RST_ENABLE 8'h00
`endif

//--- core/irq_flag_and_wakeup_edge_logic.v
// Request flag registers for peripheral, wakeup and edge-sensed pin interrupts.
// Assumes peripheral event inputs are one-cycle pulses synchronous to mclk.
//
// Overview of operation
// - Flags stay set after acceptance, clear only by software, reset to zero.
// - Writing zero clears a flag; writing one leaves it unchanged.
// - Bit 7 sets on sleep direct transfer while direct transfer enable is one.
// - Bit 6 sets when conversion completes and start/busy falls to zero.
// - Bit 3 sets on high byte match (8-bit) or 16-bit match.
// - Bit 2 sets on low byte match in 8-bit timer mode.
// - Bit 0 sets on high overflow (16-bit) or either overflow (8-bit).
// - Wakeup flag n sets when pin n is a wakeup input and shows its edge.
// - Edge select bit zero picks falling edge, one picks rising edge.
// - Edge select register is read/write and resets to all zeros.
// - Eleven external sources: eight wakeup, two request pins, one counter pin.
// - Peripheral enable bits gate flags 7, 6, 3, 2, 0; reset to zero.
// - All requests are masked while the processor mask bit is one.
//
// The plain strobed port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "irq_flag_defines.vh"
module irq_flag_and_wakeup_edge_logic (
   // Clock, reset, enable
   input wire mclk,
   input wire rst,
   input wire ce,
   // Register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // Peripheral events
   input wire direct_transfer_on,
   input wire sleep_direct_transfer,
   input wire converter_start_busy,
   input wire timer_16bit_mode,
   input wire high_byte_match,
   input wire low_byte_match,
   input wire word_match,
   input wire counter_16bit_mode,
   input wire event_count_high_ovf,
   input wire event_count_low_ovf,
   // External pins
   input wire [7:0] wakeup_pin_n,
   input wire [7:0] wakeup_pin_select,
   input wire [1:0] irq_pin_n,
   input wire [1:0] irq_pin_select,
   input wire [1:0] irq_edge_rising,
   input wire event_counter_irq_pin,
   input wire event_counter_irq_rising,
   input wire wakeup_enable,
   // Core side
   input wire condition_register_mask,
   output reg irq_request
);
   reg [7:0] periph_q, periph_d;
   reg [7:0] wake_q, wake_d;
   reg [7:0] edge_q;
   reg [7:0] pen_q;
   reg [2:0] ext_q, ext_d;
   reg [2:0] xen_q;
   reg busy_q;
   reg [10:0] sync1_q, sync2_q, last_q;
   reg [7:0] periph_set;
   reg [7:0] wake_set;
   reg [2:0] ext_set;
   wire [10:0] pins;
   wire [10:0] rise;
   wire [10:0] fall;
   wire wake_wr, periph_wr, ext_wr;

   // Edge pick: sel one means rising
   function edge_hit;
      input r;
      input f;
      input sel;
      begin
         edge_hit = sel ? r : f;
      end
   endfunction

   // Eleven external inputs, synchronised in two stages
   assign pins = {event_counter_irq_pin, irq_pin_n, wakeup_pin_n};
   assign rise = sync2_q & ~last_q;
   assign fall = ~sync2_q & last_q;
   assign periph_wr = ce & wr & (addr == `ADDR_PERIPH_FLAGS);
   assign wake_wr = ce & wr & (addr == `ADDR_WAKEUP_FLAGS);
   assign ext_wr = ce & wr & (addr == `ADDR_EXT_FLAGS);

   always @(posedge mclk) begin
      if (rst) begin
         // Preload with pin levels so release of reset shows no false edge
         sync1_q <= pins;
         sync2_q <= pins;
         last_q <= pins;
      end else if (ce) begin
         sync1_q <= pins;
         sync2_q <= sync1_q;
         last_q <= sync2_q;
      end
   end

   integer i;
   always @* begin
      periph_set = 8'h00;
      periph_set[`BIT_DT] = sleep_direct_transfer & direct_transfer_on;
      periph_set[`BIT_AD] = busy_q & ~converter_start_busy;
      periph_set[`BIT_TFH] = timer_16bit_mode ? word_match : high_byte_match;
      periph_set[`BIT_TFL] = ~timer_16bit_mode & low_byte_match;
      periph_set[`BIT_EC] = event_count_high_ovf |
         (~counter_16bit_mode & event_count_low_ovf);
      for (i = 0; i < 8; i = i + 1)
         wake_set[i] = wakeup_pin_select[i] &
            edge_hit(rise[i], fall[i], edge_q[i]);
      ext_set[0] = irq_pin_select[0] & edge_hit(rise[8], fall[8], irq_edge_rising[0]);
      ext_set[1] = irq_pin_select[1] & edge_hit(rise[9], fall[9], irq_edge_rising[1]);
      ext_set[2] = edge_hit(rise[10], fall[10], event_counter_irq_rising);
      // Zero write clears, one keeps, set wins
      periph_d = (periph_wr ? (periph_q & wdata) : periph_q) | periph_set;
      periph_d = periph_d & `PERIPH_IMPL_MASK;
      wake_d = (wake_wr ? (wake_q & wdata) : wake_q) | wake_set;
      ext_d = (ext_wr ? (ext_q & wdata[2:0]) : ext_q) | ext_set;
   end

   always @(posedge mclk) begin
      if (rst) begin
         periph_q <= `RST_FLAGS;
         wake_q <= `RST_FLAGS;
         ext_q <= 3'h0;
         edge_q <= `RST_EDGE;
         pen_q <= `RST_ENABLE;
         xen_q <= 3'h0;
         busy_q <= 1'b0;
         rdata <= 8'h00;
         irq_request <= 1'b0;
      end else if (ce) begin
         busy_q <= converter_start_busy;
         periph_q <= periph_d;
         wake_q <= wake_d;
         ext_q <= ext_d;
         if (wr && addr == `ADDR_WAKEUP_EDGE)
            edge_q <= wdata;
         if (wr && addr == `ADDR_PERIPH_ENABLE)
            pen_q <= wdata & `PERIPH_IMPL_MASK;
         if (wr && addr == `ADDR_EXT_ENABLE)
            xen_q <= wdata[2:0];
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               `ADDR_PERIPH_FLAGS: rdata <= periph_q;
               `ADDR_WAKEUP_FLAGS: rdata <= wake_q;
               `ADDR_WAKEUP_EDGE: rdata <= edge_q;
               `ADDR_PERIPH_ENABLE: rdata <= pen_q;
               `ADDR_EXT_FLAGS: rdata <= {5'h00, ext_q};
               `ADDR_EXT_ENABLE: rdata <= {5'h00, xen_q};
               default: rdata <= 8'h00;
            endcase
         end
         // Gated request toward the core
         irq_request <= ~condition_register_mask &
            ((|(periph_q & pen_q)) | (wakeup_enable & (|wake_q)) | (|(ext_q & xen_q)));
      end
   end
endmodule // irq_flag_and_wakeup_edge_logic

//--- tb/irq_flag_sva.sv
// Assertions on the request flag block
// Assumes binding to the top module
`timescale 1ns/100ps
module irq_flag_sva (
   // Watched ports
   input wire mclk, input wire rst, input wire [3:0] addr, input wire [7:0] wdata,
   input wire wr, input wire rd, input wire [7:0] rdata, input wire direct_transfer_on,
   input wire sleep_direct_transfer, input wire converter_start_busy,
   input wire condition_register_mask, input wire irq_request
);
   default clocking @(posedge mclk); endclocking
   default disable iff (rst);
   sequence rd0; rd && addr == 4'h0; endsequence
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 8'h00) else $error("idle");
   a_rsvd_zero: assert property ($past(rd) && $past(addr) == 4'h0 |->
      (rdata & 8'h32) == 8'h00) else $error("rsvd");
   a_unmapped_zero: assert property ($past(rd) && $past(addr) > 4'h5 |->
      rdata == 8'h00) else $error("unmapped");
   a_edge_rw: assert property (wr && addr == 4'h2 ##2 rd && addr == 4'h2 |=>
      rdata == $past(wdata, 3)) else $error("edge");
   a_flag_sticky: assert property ((rd0 and !wr) ##1 !wr[*2] ##1 rd0 |=>
      (rdata & $past(rdata, 3)) == $past(rdata, 3)) else $error("sticky");
   a_dt_set: assert property (sleep_direct_transfer && direct_transfer_on ##4 rd0 |=>
      rdata[7]) else $error("dt");
   a_ad_set: assert property ($fell(converter_start_busy) ##3 rd0 |=> rdata[6])
      else $error("ad");
   a_mask_blocks: assert property (condition_register_mask |=> !irq_request)
      else $error("mask");
endmodule // irq_flag_sva
bind irq_flag_and_wakeup_edge_logic irq_flag_sva u_sva (.*);

//--- tb/periph_model.sv
// Peripheral model: one-cycle event pulses
// Assumes commands change just after a rising edge
`timescale 1ns/100ps
module periph_model (
   // Command and pulses
   input wire mclk,
   input wire [6:0] ev,
   output reg [6:0] pulse
);
   initial pulse = 7'h00;
   // Busy high one cycle then back to zero match and overflow pulses
   always @(posedge mclk) pulse <= ev;
endmodule // periph_model

//--- tb/irq_flag_and_wakeup_edge_logic_tb.sv
// Bench for the request flag block
// Assumes the model and checker files are compiled first
`timescale 1ns/100ps
module irq_flag_and_wakeup_edge_logic_tb;
   reg mclk = 0, rst = 1, wr = 0, rd = 0, dto = 0, t16 = 0, msk = 0;
   reg [3:0] addr = 0;
   reg [7:0] wdata = 0, pins = 8'hff, es, xp = 0;
   reg [6:0] ev = 0, e;
   wire [6:0] p;
   wire [7:0] rdata;
   wire irq;
   integer num_errors = 0, samples_checked = 0, seed = 8, cyc = 0, i;
   reg [7:0] m = 0;
   always #5 mclk = ~mclk;
   periph_model pm (.mclk(mclk), .ev(ev), .pulse(p));
   irq_flag_and_wakeup_edge_logic dut (.mclk(mclk), .rst(rst), .ce(1'b1), .addr(addr),
      .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .direct_transfer_on(dto),
      .sleep_direct_transfer(p[5]), .converter_start_busy(p[6]), .timer_16bit_mode(t16),
      .high_byte_match(p[4]), .low_byte_match(p[3]), .word_match(p[2]),
      .counter_16bit_mode(t16), .event_count_high_ovf(p[1]), .event_count_low_ovf(p[0]),
      .wakeup_pin_n(pins), .wakeup_pin_select(8'h7f), .irq_pin_n(xp[1:0]),
      .irq_pin_select(xp[3:2]), .irq_edge_rising(xp[5:4]), .event_counter_irq_pin(xp[6]),
      .event_counter_irq_rising(xp[7]), .wakeup_enable(1'b1),
      .condition_register_mask(msk), .irq_request(irq));
   task final_report;
      begin
         $display("checks %0d errors %0d", samples_checked, num_errors);
         if (num_errors == 0 && samples_checked > 0) $display("[ PASS ]");
         else $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input [39:0] n, input [7:0] s, input [7:0] x);
      begin
         samples_checked = samples_checked + 1;
         if (s !== x) begin
            num_errors = num_errors + 1;
            $display("[FAIL] %0s exp %h got %h", n, x, s);
         end
      end
   endtask
   task wreg(input [3:0] a, input [7:0] d);
      begin
         @(posedge mclk) {wr, addr, wdata} <= {1'b1, a, d};
         @(posedge mclk) wr <= 0;
      end
   endtask
   task rchk(input [3:0] a, input [7:0] x);
      begin
         @(posedge mclk) {rd, addr} <= {1'b1, a};
         @(posedge mclk) rd <= 0;
         @(negedge mclk) chk("rdata", rdata, x);
      end
   endtask
   always @(posedge mclk) begin
      cyc = cyc + 1;
      xp <= $random(seed);
      if (cyc == 3000) begin
         num_errors = num_errors + 1;
         final_report;
      end
   end
   initial begin
      repeat (16) @(posedge mclk);
      rst <= 0;
      for (i = 0; i < 4; i = i + 1) rchk(i[3:0], 8'h00);
      wreg(4'h9, 8'hff);
      rchk(4'h9, 8'h00);
      for (i = 0; i < 4; i = i + 1) begin
         es = $random(seed);
         wreg(4'h2, es);
         rchk(4'h2, es);
      end
      $display("registers done");
      for (i = 0; i < 14; i = i + 1) begin
         if (i == 7) begin
            wreg(4'h0, 8'h00);
            m = 0;
            {dto, t16} <= 2'b11;
         end
         e = 7'h01 << (i % 7);
         @(posedge mclk) ev <= e;
         @(posedge mclk) ev <= 0;
         repeat (3) @(posedge mclk);
         m = m | {e[5] & dto, e[6], 2'h0, t16 ? e[2] : e[4], e[3] & !t16, 1'b0, e[1] | e[0] & !t16};
         rchk(4'h0, m);
      end
      wreg(4'h0, 8'hff);
      rchk(4'h0, m);
      rchk(4'h0, m);
      wreg(4'h3, 8'hff);
      rchk(4'h3, 8'hcd);
      repeat (2) @(posedge mclk);
      @(negedge mclk) chk("irq", {7'h00, irq}, 8'h01);
      @(posedge mclk) msk <= 1;
      repeat (2) @(posedge mclk);
      @(negedge mclk) chk("irq", {7'h00, irq}, 8'h00);
      $display("peripheral done");
      wreg(4'h1, 8'h00);
      wreg(4'h2, 8'h0f);
      @(posedge mclk) pins <= 8'h00;
      repeat (5) @(posedge mclk);
      @(posedge mclk) pins <= 8'hff;
      repeat (5) @(posedge mclk);
      rchk(4'h1, 8'h7f);
      wreg(4'h1, 8'h0f);
      rchk(4'h1, 8'h0f);
      $display("wakeup done");
      final_report;
   end
endmodule // irq_flag_and_wakeup_edge_logic_tb
